// ===== hw/hmb_pkg.sv
// Purpose: Shared constants for the host misc and buffer status register bank
// Assumes: One clock (pclk, 25 MHz); both ends import this package
// Notes:   Command codes, field positions, reset values and APB offsets
package hmb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes on the processor port
  localparam logic [7:0] CMD_MASK_RD = 8'h25;
  localparam logic [7:0] CMD_MASK_WR = 8'ha5;
  localparam logic [7:0] CMD_ID_RD   = 8'h27;
  localparam logic [7:0] CMD_SCR_RD  = 8'h28;
  localparam logic [7:0] CMD_SCR_WR  = 8'ha8;
  localparam logic [7:0] CMD_SRST_WR = 8'ha9;
  localparam logic [7:0] CMD_BST_RD  = 8'h2c;
  localparam logic [7:0] CMD_BST_WR  = 8'hac;

  ////////////////////////////////////////////////////////////////////////////
  // Values and widths
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned MASK_W          = 8;
  localparam logic [15:0] SRST_KEY        = 16'h00f6;
  localparam logic [15:0] MASK_RST        = 16'h0000;
  localparam logic [15:0] SCR_RST         = 16'h0000;
  localparam logic [15:0] ZERO_WORD       = 16'h0000;
  // Arbitrary identification value, not tied to any real part
  localparam logic [15:0] PART_ID_DEFAULT = 16'h5a01;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer status field positions
  localparam int unsigned BS_ISO_A_FULL   = 0;
  localparam int unsigned BS_ISO_B_FULL   = 1;
  localparam int unsigned BS_PERIODIC_RUN = 2;
  localparam int unsigned BS_ASYNC_RUN    = 3;
  localparam int unsigned BS_CLR_HALF     = 4;
  localparam int unsigned BS_ISO_A_USE    = 5;
  localparam int unsigned BS_ISO_B_USE    = 6;
  localparam int unsigned BS_ISO_A_DONE   = 8;
  localparam int unsigned BS_ISO_B_DONE   = 9;
  localparam int unsigned BS_HALF         = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Host controller APB map and status fields
  localparam logic [11:0] HOST_CMD_OFS   = 12'h000;
  localparam logic [11:0] HOST_WDATA_OFS = 12'h004;
  localparam logic [11:0] HOST_STAT_OFS  = 12'h008;
  localparam logic [11:0] HOST_RDATA_OFS = 12'h00c;
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_DONE        = 1;

endpackage

// ===== hw/hmb_if.sv
// Purpose: Processor command port between host driver end and device end
// Assumes: Both ends on pclk; one command in flight at a time
// Notes:   Device answers every command with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
interface hmb_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        ack;
  logic [15:0] ack_rdata;

  modport dev (
    input  pclk, presetn, cmd_valid, cmd_code, cmd_wdata,
    output ack, ack_rdata
  );

  modport host (
    input  pclk, presetn, ack, ack_rdata,
    output cmd_valid, cmd_code, cmd_wdata
  );
endinterface
`default_nettype wire

// ===== hw/hmb_dev.sv
// Purpose: Device end: interrupt mask, part id, scratch, soft reset, buffer status
// Assumes: Commands come from logic on pclk; engine inputs are on pclk
// Notes:   Every command is acked one cycle after cmd_valid
//
// Contract
// - Mask bits 7..5 reset zero, unmask list/clock/suspend
// - Mask bits 4..0 reset zero, unmask five events
// - Mask read 25h, written A5h
// - Fixed read-only identification word, writes unsupported
// - Scratch word resets zero, holds writes
// - Writing F6h soft-resets all registers
// - Soft reset only writable via A9h
// - Bit 10 shows active paired half
// - Bits 9,8 set once iso buffer consumed
// - Bits 6,5 show iso buffer in use
// - Bit 4 clears paired half while async idle
// - Bit 3 runs the asynchronous list
// - Bit 2 runs the interrupt list
// - Bits 1,0 mark iso buffers full
// - Buffer status read 2Ch, written ACh
// - Interrupt needs enable bit and global enable
`timescale 1ns/1ps
`default_nettype none
module hmb_dev
  import hmb_pkg::*;
#(
  parameter logic [15:0] PART_ID = PART_ID_DEFAULT
) (
  // Processor command port
  hmb_if.dev                link,
  // Engine events and levels
  input  wire logic         iso_a_consumed_set,
  input  wire logic         iso_b_consumed_set,
  input  wire logic         iso_a_busy,
  input  wire logic         iso_b_busy,
  input  wire logic         paired_half_flip,
  // Interrupt sources and global enable
  input  wire logic [MASK_W-1:0] irq_events,
  input  wire logic         global_irq_enable,
  // Control outputs
  output logic              irq_q,
  output logic              async_list_run,
  output logic              periodic_list_run,
  output logic              iso_list_a_full,
  output logic              iso_list_b_full,
  output logic              soft_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic        wr_mask;
  logic        wr_scr;
  logic        wr_bst;
  logic        srst_d;
  logic        srst_q;
  logic [15:0] wdata;

  assign wdata   = link.cmd_wdata;
  assign wr_mask = link.cmd_valid && (link.cmd_code == CMD_MASK_WR);
  assign wr_scr  = link.cmd_valid && (link.cmd_code == CMD_SCR_WR);
  assign wr_bst  = link.cmd_valid && (link.cmd_code == CMD_BST_WR);
  // Only code A9h with the key triggers; no read code exists
  assign srst_d  = link.cmd_valid && (link.cmd_code == CMD_SRST_WR)
                   && (wdata == SRST_KEY);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [MASK_W-1:0] mask_q;
  logic [15:0]       scr_q;
  logic [3:0]        ctl_q;
  logic              a_done_q;
  logic              b_done_q;
  logic              a_use_q;
  logic              b_use_q;
  logic              half_q;
  logic [15:0]       bst;
  logic [15:0]       rd_d;
  logic [15:0]       rdata_q;
  logic              ack_q;

  // Soft reset strobe, applied on the cycle after the command
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_d;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      mask_q <= MASK_RST[MASK_W-1:0];
    end else if (srst_q) begin
      mask_q <= MASK_RST[MASK_W-1:0];
    end else if (wr_mask) begin
      mask_q <= wdata[MASK_W-1:0];
    end
  end

  // Scratch word
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      scr_q <= SCR_RST;
    end else if (srst_q) begin
      scr_q <= SCR_RST;
    end else if (wr_scr) begin
      scr_q <= wdata;
    end
  end

  // List run and buffer full controls
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      ctl_q <= 4'h0;
    end else if (srst_q) begin
      ctl_q <= 4'h0;
    end else if (wr_bst) begin
      ctl_q <= wdata[BS_ASYNC_RUN:BS_ISO_A_FULL];
    end
  end

  // Consumed flags: engine set wins over reload clear
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      a_done_q <= 1'b0;
      b_done_q <= 1'b0;
    end else if (srst_q) begin
      a_done_q <= 1'b0;
      b_done_q <= 1'b0;
    end else begin
      if (iso_a_consumed_set) begin
        a_done_q <= 1'b1;
      end else if (wr_bst && wdata[BS_ISO_A_FULL]) begin
        a_done_q <= 1'b0;
      end
      if (iso_b_consumed_set) begin
        b_done_q <= 1'b1;
      end else if (wr_bst && wdata[BS_ISO_B_FULL]) begin
        b_done_q <= 1'b0;
      end
    end
  end

  // In-use status follows the engine
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      a_use_q <= 1'b0;
      b_use_q <= 1'b0;
    end else if (srst_q) begin
      a_use_q <= 1'b0;
      b_use_q <= 1'b0;
    end else begin
      a_use_q <= iso_a_busy;
      b_use_q <= iso_b_busy;
    end
  end

  // Paired half: flip wins, clear only while async list idle
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      half_q <= 1'b0;
    end else if (srst_q) begin
      half_q <= 1'b0;
    end else if (paired_half_flip) begin
      half_q <= ~half_q;
    end else if (wr_bst && wdata[BS_CLR_HALF] && !ctl_q[BS_ASYNC_RUN]) begin
      half_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer status image, clear bit and reserved bits read zero
  always_comb begin
    bst                  = ZERO_WORD;
    bst[BS_ISO_A_FULL]   = ctl_q[BS_ISO_A_FULL];
    bst[BS_ISO_B_FULL]   = ctl_q[BS_ISO_B_FULL];
    bst[BS_PERIODIC_RUN] = ctl_q[BS_PERIODIC_RUN];
    bst[BS_ASYNC_RUN]    = ctl_q[BS_ASYNC_RUN];
    bst[BS_ISO_A_USE]    = a_use_q;
    bst[BS_ISO_B_USE]    = b_use_q;
    bst[BS_ISO_A_DONE]   = a_done_q;
    bst[BS_ISO_B_DONE]   = b_done_q;
    bst[BS_HALF]         = half_q;
  end

  // Read mux; writes and unknown codes answer zero
  always_comb begin
    rd_d = ZERO_WORD;
    unique case (link.cmd_code)
      CMD_MASK_RD: rd_d[MASK_W-1:0] = mask_q;
      CMD_ID_RD:   rd_d = PART_ID;
      CMD_SCR_RD:  rd_d = scr_q;
      CMD_BST_RD:  rd_d = bst;
      default:     rd_d = ZERO_WORD;
    endcase
  end

  // Answer every command one cycle later
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      ack_q   <= 1'b0;
      rdata_q <= ZERO_WORD;
    end else begin
      ack_q   <= link.cmd_valid;
      rdata_q <= link.cmd_valid ? rd_d : ZERO_WORD;
    end
  end

  // Interrupt request gated by mask and global enable
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= global_irq_enable && |(irq_events & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign link.ack          = ack_q;
  assign link.ack_rdata    = rdata_q;
  assign async_list_run    = ctl_q[BS_ASYNC_RUN];
  assign periodic_list_run = ctl_q[BS_PERIODIC_RUN];
  assign iso_list_a_full   = ctl_q[BS_ISO_A_FULL];
  assign iso_list_b_full   = ctl_q[BS_ISO_B_FULL];
  assign soft_reset_pulse  = srst_q;

  // Parameter check
  if (MASK_W > DATA_W) begin : g_chk
    $error("mask wider than data word");
  end

endmodule
`default_nettype wire

// ===== hw/hmb_cmd_port.sv
// Purpose: Driver-side sequencer issuing one command and awaiting its ack
// Assumes: start only while busy_q low
// Notes:   Strips the paired-half clear while the async list may be running
`timescale 1ns/1ps
`default_nettype none
module hmb_cmd_port
  import hmb_pkg::*;
(
  // Command port to the device
  hmb_if.host               link,
  // Request from the register side
  input  wire logic         start,
  input  wire logic [7:0]   code,
  input  wire logic [15:0]  wdata,
  // Result
  output logic              busy_q,
  output logic              done_q,
  output logic [15:0]       rdata_q
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } hmb_cp_state_t;

  hmb_cp_state_t state_q;
  logic          valid_q;
  logic [7:0]    code_q;
  logic [15:0]   wdata_q;
  logic [15:0]   wdata_d;
  logic          run_seen_q;

  // Clear bit only honoured when list known idle and staying idle
  always_comb begin
    wdata_d = wdata;
    if (code == CMD_BST_WR && (run_seen_q || wdata[BS_ASYNC_RUN])) begin
      wdata_d[BS_CLR_HALF] = 1'b0;
    end
  end

  // Sequencer
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_q <= ST_IDLE;
      valid_q <= 1'b0;
      code_q  <= 8'h00;
      wdata_q <= ZERO_WORD;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= ZERO_WORD;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_ISSUE;
            valid_q <= 1'b1;
            code_q  <= code;
            wdata_q <= wdata_d;
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
          end
        end
        ST_ISSUE: begin
          state_q <= ST_WAIT;
          valid_q <= 1'b0;
        end
        ST_WAIT: begin
          if (link.ack) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            rdata_q <= link.ack_rdata;
          end
        end
      endcase
    end
  end

  // Shadow of the async run bit from reads, writes and soft reset
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      run_seen_q <= 1'b0;
    end else if (state_q == ST_WAIT && link.ack) begin
      if (code_q == CMD_BST_RD) begin
        run_seen_q <= link.ack_rdata[BS_ASYNC_RUN];
      end else if (code_q == CMD_BST_WR) begin
        run_seen_q <= wdata_q[BS_ASYNC_RUN];
      end else if (code_q == CMD_SRST_WR && wdata_q == SRST_KEY) begin
        run_seen_q <= 1'b0;
      end
    end
  end

  assign link.cmd_valid = valid_q;
  assign link.cmd_code  = code_q;
  assign link.cmd_wdata = wdata_q;

endmodule
`default_nettype wire

// ===== hw/hmb_host.sv
// Purpose: Driver end: APB slave that issues processor commands to the device
// Assumes: APB master on pclk; one command at a time
// Notes:   CMD write while busy is refused with pslverr
`timescale 1ns/1ps
`default_nettype none
module hmb_host
  import hmb_pkg::*;
(
  // APB slave
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Command port to the device
  hmb_if.host               link
);

  logic        access;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        start_q;
  logic [7:0]  code_q;
  logic [15:0] wreg_q;
  logic        busy;
  logic        done;
  logic [15:0] rdata;

  assign access = psel && penable && !pready_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (access) begin
        unique case (paddr)
          HOST_CMD_OFS:   pslverr_q <= pwrite && busy;
          HOST_WDATA_OFS: prdata_q  <= {16'h0000, wreg_q};
          HOST_STAT_OFS:  begin
            prdata_q[ST_BUSY] <= busy;
            prdata_q[ST_DONE] <= done;
          end
          HOST_RDATA_OFS: prdata_q  <= {16'h0000, rdata};
          default:        pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Command launch and write data holding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      code_q  <= 8'h00;
      wreg_q  <= ZERO_WORD;
    end else begin
      start_q <= access && pwrite && (paddr == HOST_CMD_OFS) && !busy;
      if (access && pwrite && (paddr == HOST_CMD_OFS) && !busy) begin
        code_q <= pwdata[7:0];
      end
      if (access && pwrite && (paddr == HOST_WDATA_OFS)) begin
        wreg_q <= pwdata[15:0];
      end
    end
  end

  hmb_cmd_port u_cmd (
    .link    (link),
    .start   (start_q),
    .code    (code_q),
    .wdata   (wreg_q),
    .busy_q  (busy),
    .done_q  (done),
    .rdata_q (rdata)
  );

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

// ===== sim/hmb_props.sv
// Purpose: Assertions on the command link between driver end and device end
// Assumes: One clock; device acks every command one cycle later
// Notes:   Shadows of mask and scratch give expected read-back words
`timescale 1ns/1ps
`default_nettype none
module hmb_props
  import hmb_pkg::*;
#(
  parameter logic [15:0] PART_ID = PART_ID_DEFAULT
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Link signals
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        ack,
  input wire logic [15:0] ack_rdata
);
  logic [7:0]  mask_q;
  logic [15:0] scr_q;
  logic        srst;
  logic        run_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Soft reset command seen on the link
  assign srst = cmd_valid && cmd_code == CMD_SRST_WR && cmd_wdata == SRST_KEY;

  // Mask shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_q <= 8'h00;
    else if (srst) mask_q <= 8'h00;
    else if (cmd_valid && cmd_code == CMD_MASK_WR) mask_q <= cmd_wdata[7:0];
  end

  // Scratch shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) scr_q <= 16'h0000;
    else if (srst) scr_q <= 16'h0000;
    else if (cmd_valid && cmd_code == CMD_SCR_WR) scr_q <= cmd_wdata;
  end

  // Async run shadow from status writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 1'b0;
    else if (srst) run_q <= 1'b0;
    else if (cmd_valid && cmd_code == CMD_BST_WR) run_q <= cmd_wdata[BS_ASYNC_RUN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link properties
  property p_ack_timing;
    cmd_valid |=> ack;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("ack missing");
  property p_ack_cause;
    ack |-> $past(cmd_valid);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without command");
  property p_spacing;
    cmd_valid |=> !cmd_valid [*2];
  endproperty
  a_spacing: assert property (p_spacing) else $error("commands too close");
  property p_write_zero;
    cmd_valid && cmd_code[7] |=> ack_rdata == ZERO_WORD;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write returned data");
  property p_id;
    cmd_valid && cmd_code == CMD_ID_RD |=> ack_rdata == PART_ID;
  endproperty
  a_id: assert property (p_id) else $error("id word wrong");
  property p_mask;
    cmd_valid && cmd_code == CMD_MASK_RD |=> ack_rdata == {8'h00, mask_q};
  endproperty
  a_mask: assert property (p_mask) else $error("mask read wrong");
  property p_scratch;
    cmd_valid && cmd_code == CMD_SCR_RD |=> ack_rdata == scr_q;
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch read wrong");
  property p_status_rsvd;
    cmd_valid && cmd_code == CMD_BST_RD |=> (ack_rdata & 16'hf890) == ZERO_WORD;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved set");
  property p_clr_idle;
    cmd_valid && cmd_code == CMD_BST_WR && cmd_wdata[BS_CLR_HALF]
      |-> !run_q && !cmd_wdata[BS_ASYNC_RUN];
  endproperty
  a_clr_idle: assert property (p_clr_idle) else $error("half clear while running");
endmodule
`default_nettype wire

// ===== sim/hmb_test.sv
// Purpose: Self-checking bench for both ends over APB
// Assumes: pclk 25 MHz; host APB map per the package
// Notes:   Each command is issued, polled to done, then read back
`timescale 1ns/1ps
`default_nettype none
module hmb_test
  import hmb_pkg::*;
;
  // Arbitrary identification value
  localparam logic [15:0] ID = 16'h1c07;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        iso_a_consumed_set, iso_b_consumed_set, iso_a_busy, iso_b_busy;
  logic        paired_half_flip, global_irq_enable, irq_q, soft_reset_pulse;
  logic        async_list_run, periodic_list_run, iso_list_a_full, iso_list_b_full;
  logic [7:0]  irq_events;
  int          num_errors, n_compared, cyc, n_srst;

  hmb_if i_hmb_if (.pclk(pclk), .presetn(presetn));
  hmb_host i_hmb_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_hmb_if));
  hmb_dev #(.PART_ID(ID)) i_hmb_dev (.link(i_hmb_if),
    .iso_a_consumed_set(iso_a_consumed_set), .iso_b_consumed_set(iso_b_consumed_set),
    .iso_a_busy(iso_a_busy), .iso_b_busy(iso_b_busy), .paired_half_flip(paired_half_flip),
    .irq_events(irq_events), .global_irq_enable(global_irq_enable), .irq_q(irq_q),
    .async_list_run(async_list_run), .periodic_list_run(periodic_list_run),
    .iso_list_a_full(iso_list_a_full), .iso_list_b_full(iso_list_b_full),
    .soft_reset_pulse(soft_reset_pulse));
  hmb_props #(.PART_ID(ID)) i_hmb_props (.pclk(pclk), .presetn(presetn),
    .cmd_valid(i_hmb_if.cmd_valid), .cmd_code(i_hmb_if.cmd_code),
    .cmd_wdata(i_hmb_if.cmd_wdata), .ack(i_hmb_if.ack), .ack_rdata(i_hmb_if.ack_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and soft reset pulse count
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (soft_reset_pulse === 1'b1) n_srst++;
    if (cyc == 6000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // APB transfer held until pready; release left to the caller
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask
  // Wait for busy low and done high, then fetch the answer
  task automatic poll();
    rd = 32'h1;
    while (rd[1:0] !== 2'b10) rdr(HOST_STAT_OFS);
    rdr(HOST_RDATA_OFS);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] d);
    wr(HOST_WDATA_OFS, {16'h0000, d});
    wr(HOST_CMD_OFS, {24'h000000, c});
    poll();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    iso_a_consumed_set = 1'b0;
    iso_b_consumed_set = 1'b0;
    iso_a_busy = 1'b0;
    iso_b_busy = 1'b0;
    paired_half_flip = 1'b0;
    irq_events = 8'h00;
    global_irq_enable = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(CMD_MASK_RD, 16'h0);
    chk("mask_rst", rd, 32'h0);
    cmd(CMD_SCR_RD, 16'h0);
    chk("scr_rst", rd, 32'h0);
    cmd(CMD_BST_RD, 16'h0);
    chk("status_rst", rd, 32'h0);
    cmd(8'ha7, 16'hffff);
    cmd(CMD_ID_RD, 16'h0);
    chk("part_id", rd, {16'h0, ID});
    // Mask width and interrupt gating
    cmd(CMD_MASK_WR, 16'hffff);
    cmd(CMD_MASK_RD, 16'h0);
    chk("mask_rsvd", rd, 32'h00ff);
    irq_events <= 8'hff;
    repeat (3) @(posedge pclk);
    chk("irq_global_off", irq_q, 1'b0);
    global_irq_enable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      cmd(CMD_MASK_WR, 16'h0001 << i);
      irq_events <= ~(8'h01 << i);
      repeat (3) @(posedge pclk);
      chk("irq_masked", irq_q, 1'b0);
      irq_events <= 8'h01 << i;
      repeat (3) @(posedge pclk);
      chk("irq_enabled", irq_q, 1'b1);
    end
    irq_events <= 8'h00;
    cmd(CMD_SCR_WR, 16'ha55a);
    cmd(CMD_SCR_RD, 16'h0);
    chk("scr_hold", rd, 32'ha55a);
    // Buffer status with engine activity
    cmd(CMD_BST_WR, 16'hffff);
    chk("run_outs", {async_list_run, periodic_list_run, iso_list_b_full, iso_list_a_full},
        4'hf);
    iso_a_busy <= 1'b1;
    iso_b_busy <= 1'b1;
    iso_a_consumed_set <= 1'b1;
    iso_b_consumed_set <= 1'b1;
    paired_half_flip <= 1'b1;
    @(posedge pclk);
    iso_a_consumed_set <= 1'b0;
    iso_b_consumed_set <= 1'b0;
    paired_half_flip <= 1'b0;
    cmd(CMD_BST_RD, 16'h0);
    chk("status_engine", rd, 32'h076f);
    iso_a_busy <= 1'b0;
    iso_b_busy <= 1'b0;
    cmd(CMD_BST_WR, 16'h0010);
    cmd(CMD_BST_RD, 16'h0);
    chk("clr_while_run", rd, 32'h0700);
    chk("async_off", async_list_run, 1'b0);
    cmd(CMD_BST_WR, 16'h0010);
    cmd(CMD_BST_RD, 16'h0);
    chk("clr_half", rd, 32'h0300);
    cmd(CMD_BST_WR, 16'h0003);
    cmd(CMD_BST_RD, 16'h0);
    chk("full_again", rd, 32'h0003);
    // Soft reset
    cmd(CMD_SRST_WR, 16'h00f5);
    cmd(CMD_SCR_RD, 16'h0);
    chk("srst_bad_key", rd, 32'ha55a);
    cmd(8'h29, 16'h0);
    chk("srst_no_read", rd, 32'h0);
    cmd(CMD_SRST_WR, SRST_KEY);
    chk("srst_pulses", n_srst, 1);
    cmd(CMD_MASK_RD, 16'h0);
    chk("mask_srst", rd, 32'h0);
    cmd(CMD_SCR_RD, 16'h0);
    chk("scr_srst", rd, 32'h0);
    cmd(CMD_BST_RD, 16'h0);
    chk("status_srst", rd, 32'h0);
    cmd(CMD_ID_RD, 16'h0);
    chk("id_srst", rd, {16'h0, ID});
    // APB refusals: unmapped address, command while busy
    rdr(12'h010);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    wr(HOST_WDATA_OFS, 32'h0001);
    apb(1'b1, HOST_CMD_OFS, {24'h0, CMD_SCR_WR});
    apb(1'b1, HOST_CMD_OFS, {24'h0, CMD_MASK_WR});
    idle();
    chk("busy_err", err, 1'b1);
    poll();
    cmd(CMD_MASK_RD, 16'h0);
    chk("busy_ignored", rd, 32'h0);
    cmd(CMD_SCR_RD, 16'h0);
    chk("first_taken", rd, 32'h0001);
    conclude();
  end
endmodule
`default_nettype wire
